/* File: src/ect_timer.sv */
// The register addresses and the plain strobed port are this design's own decisions.
`include "ect_params.svh"

//
// Overview of operation
// - Count up on each selected clock pulse
// - Wrap from max to zero sets flag
// - Wrap flag with enable raises interrupt
// - Equal count sets match flag A/B
// - Match pulse at last equal cycle
// - Match flag with enable raises interrupt
// - Match drives pin per action field
// - Actions: keep, low, high, toggle
// - Pin low after reset until match
// - Clear source 01/10 clears on match
// - Source 11 clears on clear-pin rise
// - Gate mode halts counting after clear
// - Selected trigger edge resumes counting
// - Edges: off, rising, falling, both
// - Flag clears by read one, write zero
// - Clear beats same-cycle count write
// - Count write beats same-cycle increment
// - Constant write suppresses same-cycle match
// - Priority toggle, then high, then low
// - Internal increments on divided-clock falling edge
module ect_timer (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input ect_pkg::ect_bus_req_t i_bus,
   input wire logic i_ext_clock_pin,
   input wire logic i_trigger_input_pin,
   input wire logic i_external_clear_pin,
   output logic [7:0] o_rdata,
   output logic o_wave_output_pin,
   output ect_pkg::ect_irq_t o_irq
);
   import ect_pkg::*;

   localparam int PIN_EXT = 0;
   localparam int PIN_TRIG = 1;
   localparam int PIN_CLR = 2;

   ect_state_t state;
   ect_state_t next_state;

   logic [`ECT_NUM_PINS-1:0] pin_raw;
   ect_pin_evt_t pin_evt [`ECT_NUM_PINS];

   // Register port decode
   logic wr_pcr;
   logic wr_scr;
   logic wr_csr;
   logic wr_cnt;
   logic wr_const_a;
   logic wr_const_b;
   logic rd_csr;

   // Counting and matching terms
   logic [2:0] tap;
   logic sel_lvl;
   logic inc_src;
   logic inc;
   logic match_a;
   logic match_b;
   logic clear;
   logic trig_evt;
   logic wrap;
   logic want_toggle;
   logic want_high;
   logic want_low;

   // Every outside pin passes its own synchroniser
   assign pin_raw[PIN_EXT] = i_ext_clock_pin;
   assign pin_raw[PIN_TRIG] = i_trigger_input_pin;
   assign pin_raw[PIN_CLR] = i_external_clear_pin;

   generate
      for (genvar g = 0; g < `ECT_NUM_PINS; g++) begin : g_sync
         ect_pin_sync u_sync (
            .i_clk_sys(i_clk_sys),
            .i_reset(i_reset),
            .i_pin(pin_raw[g]),
            .o_evt(pin_evt[g])
         );
      end
   endgenerate

   // Strobes qualified by address
   assign wr_pcr = i_bus.wr && (i_bus.addr == `ECT_OFS_PCR);
   assign wr_scr = i_bus.wr && (i_bus.addr == `ECT_OFS_SCR);
   assign wr_csr = i_bus.wr && (i_bus.addr == `ECT_OFS_CSR);
   assign wr_cnt = i_bus.wr && (i_bus.addr == `ECT_OFS_CNT);
   assign wr_const_a = i_bus.wr && (i_bus.addr == `ECT_OFS_CONST_A);
   assign wr_const_b = i_bus.wr && (i_bus.addr == `ECT_OFS_CONST_B);
   assign rd_csr = i_bus.rd && (i_bus.addr == `ECT_OFS_CSR);

   // Prescaler tap: select codes 1 to 3, refined by the internal select bit
   assign tap = {state.cks[1:0] - 2'h1, 1'b0} + {2'b00, state.icks} + 3'h1;

   // Level of the selected clock; except in both-edge mode an increment is its falling edge
   always_comb begin
      case (state.cks)
         `ECT_CKS_STOP: sel_lvl = 1'b1;
         `ECT_CKS_STOP_ALT: sel_lvl = 1'b1;
         `ECT_CKS_EXT_RISE: sel_lvl = ~pin_evt[PIN_EXT].level;
         `ECT_CKS_EXT_FALL: sel_lvl = pin_evt[PIN_EXT].level;
         `ECT_CKS_EXT_BOTH: sel_lvl = pin_evt[PIN_EXT].level;
         default: sel_lvl = state.prescaler[tap];
      endcase
   end

   // A source switch that pulls the level low is seen as an edge
   assign inc_src = (state.cks == `ECT_CKS_EXT_BOTH) ?
                    (pin_evt[PIN_EXT].rise | pin_evt[PIN_EXT].fall) :
                    (state.sel_prev & ~sel_lvl);

   // Counting stops while halted in gate mode
   assign inc = inc_src && !(state.gate_en && state.halted);

   // Match fires on the increment that ends the equal period
   assign match_a = inc && (state.count == state.const_a) && !wr_const_a;
   assign match_b = inc && (state.count == state.const_b) && !wr_const_b;

   // Count clear sources
   always_comb begin
      case (state.clr_src)
         ECT_CLR_MATCH_A: clear = match_a;
         ECT_CLR_MATCH_B: clear = match_b;
         ECT_CLR_PIN: clear = pin_evt[PIN_CLR].rise;
         default: clear = 1'b0;
      endcase
   end

   // Trigger edge decode
   always_comb begin
      case (state.trig_edge)
         ECT_EDGE_RISE: trig_evt = pin_evt[PIN_TRIG].rise;
         ECT_EDGE_FALL: trig_evt = pin_evt[PIN_TRIG].fall;
         ECT_EDGE_BOTH: trig_evt = pin_evt[PIN_TRIG].rise | pin_evt[PIN_TRIG].fall;
         default: trig_evt = 1'b0;
      endcase
   end

   // Wrap only on a real increment out of the top value
   assign wrap = inc && (state.count == `ECT_COUNT_MAX) && !clear && !wr_cnt;

   // Requested pin actions of both matches
   assign want_toggle = (match_a && (state.act_a == ECT_ACT_TOGGLE)) ||
                        (match_b && (state.act_b == ECT_ACT_TOGGLE));
   assign want_high = (match_a && (state.act_a == ECT_ACT_HIGH)) ||
                      (match_b && (state.act_b == ECT_ACT_HIGH));
   assign want_low = (match_a && (state.act_a == ECT_ACT_LOW)) ||
                     (match_b && (state.act_b == ECT_ACT_LOW));

   // Next state of the whole timer
   always_comb begin
      next_state = state;

      // Free-running prescaler
      next_state.prescaler = state.prescaler + `ECT_PRESC_W'(1);
      next_state.sel_prev = sel_lvl;

      // Count register: clear, then write, then increment
      if (clear) begin
         next_state.count = 8'h00;
      end else if (wr_cnt) begin
         next_state.count = i_bus.wdata;
      end else if (inc) begin
         next_state.count = state.count + 8'h01;
      end

      // Constant registers always take the write
      if (wr_const_a) begin
         next_state.const_a = i_bus.wdata;
      end
      if (wr_const_b) begin
         next_state.const_b = i_bus.wdata;
      end

      // Primary control register
      if (wr_pcr) begin
         next_state.ie_b = i_bus.wdata[`ECT_PCR_IE_B];
         next_state.ie_a = i_bus.wdata[`ECT_PCR_IE_A];
         next_state.ie_wrap = i_bus.wdata[`ECT_PCR_IE_WRAP];
         next_state.clr_src = ect_clear_t'(i_bus.wdata[`ECT_PCR_CLR_HI:`ECT_PCR_CLR_LO]);
         next_state.cks = i_bus.wdata[`ECT_PCR_CKS_HI:`ECT_PCR_CKS_LO];
      end

      // Secondary control register
      if (wr_scr) begin
         next_state.trig_edge = ect_edge_t'(i_bus.wdata[`ECT_SCR_EDGE_HI:`ECT_SCR_EDGE_LO]);
         next_state.gate_en = i_bus.wdata[`ECT_SCR_GATE];
         next_state.icks = i_bus.wdata[`ECT_SCR_ICKS];
      end

      // Action fields; flags clear only when armed by a read of one
      if (wr_csr) begin
         next_state.act_b = ect_action_t'(i_bus.wdata[`ECT_CSR_ACT_B_HI:`ECT_CSR_ACT_B_LO]);
         next_state.act_a = ect_action_t'(i_bus.wdata[`ECT_CSR_ACT_A_HI:`ECT_CSR_ACT_A_LO]);
         if (state.armed[2] && !i_bus.wdata[`ECT_CSR_FLAG_B]) begin
            next_state.flag_b = 1'b0;
         end
         if (state.armed[1] && !i_bus.wdata[`ECT_CSR_FLAG_A]) begin
            next_state.flag_a = 1'b0;
         end
         if (state.armed[0] && !i_bus.wdata[`ECT_CSR_FLAG_WRAP]) begin
            next_state.flag_wrap = 1'b0;
         end
         next_state.armed = 3'h0;
      end else if (rd_csr) begin
         next_state.armed = {state.flag_b, state.flag_a, state.flag_wrap};
      end

      // Hardware set wins over a clear in the same cycle
      if (match_b) begin
         next_state.flag_b = 1'b1;
      end
      if (match_a) begin
         next_state.flag_a = 1'b1;
      end
      if (wrap) begin
         next_state.flag_wrap = 1'b1;
      end

      // Gate mode: halt after a clear, resume on the chosen edge
      if (state.gate_en && clear) begin
         next_state.halted = 1'b1;
      end else if (state.halted && trig_evt) begin
         next_state.halted = 1'b0;
      end

      // Waveform pin, toggle first, then high, then low
      if (want_toggle) begin
         next_state.wave = ~state.wave;
      end else if (want_high) begin
         next_state.wave = 1'b1;
      end else if (want_low) begin
         next_state.wave = 1'b0;
      end

      // Interrupt requests follow flags and enables
      next_state.irq.wrap = next_state.flag_wrap && next_state.ie_wrap;
      next_state.irq.match_a = next_state.flag_a && next_state.ie_a;
      next_state.irq.match_b = next_state.flag_b && next_state.ie_b;

      // Read data for the cycle after a read strobe
      next_state.rdata = 8'h00;
      if (i_bus.rd) begin
         case (i_bus.addr)
            `ECT_OFS_PCR: begin
               next_state.rdata = {state.ie_b, state.ie_a, state.ie_wrap,
                                   state.clr_src, state.cks};
            end
            `ECT_OFS_SCR: begin
               next_state.rdata = `ECT_SCR_ONES |
                                  {3'b000, state.trig_edge, state.gate_en, 1'b0, state.icks};
            end
            `ECT_OFS_CSR: begin
               next_state.rdata = {state.flag_b, state.flag_a, state.flag_wrap, 1'b1,
                                   state.act_b, state.act_a};
            end
            `ECT_OFS_CNT: begin
               next_state.rdata = state.count;
            end
            `ECT_OFS_CONST_A: begin
               next_state.rdata = state.const_a;
            end
            `ECT_OFS_CONST_B: begin
               next_state.rdata = state.const_b;
            end
            default: begin
               next_state.rdata = `ECT_UNMAPPED;
            end
         endcase
      end
   end

   // State register; the pin starts low and the gate starts halted
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state <= '0;
         state.count <= `ECT_RST_REG;
         state.const_a <= `ECT_RST_CONST;
         state.const_b <= `ECT_RST_CONST;
         state.halted <= 1'b1;
         state.sel_prev <= 1'b1;
         state.wave <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from the state register
   assign o_rdata = state.rdata;
   assign o_wave_output_pin = state.wave;
   assign o_irq = state.irq;
endmodule

/* File: src/ect_params.svh */
`ifndef ECT_PARAMS_SVH
`define ECT_PARAMS_SVH

// Register offsets on the plain register port
`define ECT_ADDR_W 3
`define ECT_OFS_PCR 3'h0
`define ECT_OFS_SCR 3'h1
`define ECT_OFS_CSR 3'h2
`define ECT_OFS_CNT 3'h3
`define ECT_OFS_CONST_A 3'h4
`define ECT_OFS_CONST_B 3'h5

// primary_control_reg fields
`define ECT_PCR_IE_B 7
`define ECT_PCR_IE_A 6
`define ECT_PCR_IE_WRAP 5
`define ECT_PCR_CLR_HI 4
`define ECT_PCR_CLR_LO 3
`define ECT_PCR_CKS_HI 2
`define ECT_PCR_CKS_LO 0

// secondary_control_reg fields
`define ECT_SCR_EDGE_HI 4
`define ECT_SCR_EDGE_LO 3
`define ECT_SCR_GATE 2
`define ECT_SCR_ICKS 0
`define ECT_SCR_ONES 8'hE2

// control_status_reg fields
`define ECT_CSR_FLAG_B 7
`define ECT_CSR_FLAG_A 6
`define ECT_CSR_FLAG_WRAP 5
`define ECT_CSR_RES 4
`define ECT_CSR_ACT_B_HI 3
`define ECT_CSR_ACT_B_LO 2
`define ECT_CSR_ACT_A_HI 1
`define ECT_CSR_ACT_A_LO 0

// Clock select codes
`define ECT_CKS_STOP 3'h0
`define ECT_CKS_STOP_ALT 3'h4
`define ECT_CKS_EXT_RISE 3'h5
`define ECT_CKS_EXT_FALL 3'h6
`define ECT_CKS_EXT_BOTH 3'h7

// Reset values and sizes
`define ECT_RST_REG 8'h00
`define ECT_RST_CONST 8'hFF
`define ECT_COUNT_MAX 8'hFF
`define ECT_UNMAPPED 8'h00
`define ECT_PRESC_W 7
`define ECT_NUM_PINS 3

`endif

/* File: src/ect_pkg.sv */
`include "ect_params.svh"

package ect_pkg;

   // Waveform action on a compare match
   typedef enum logic [1:0] {
      ECT_ACT_KEEP = 2'b00,
      ECT_ACT_LOW = 2'b01,
      ECT_ACT_HIGH = 2'b10,
      ECT_ACT_TOGGLE = 2'b11
   } ect_action_t;

   // Count clear source
   typedef enum logic [1:0] {
      ECT_CLR_NONE = 2'b00,
      ECT_CLR_MATCH_A = 2'b01,
      ECT_CLR_MATCH_B = 2'b10,
      ECT_CLR_PIN = 2'b11
   } ect_clear_t;

   // Trigger edge select
   typedef enum logic [1:0] {
      ECT_EDGE_OFF = 2'b00,
      ECT_EDGE_RISE = 2'b01,
      ECT_EDGE_FALL = 2'b10,
      ECT_EDGE_BOTH = 2'b11
   } ect_edge_t;

   // Register port request
   typedef struct packed {
      logic [`ECT_ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ect_bus_req_t;

   // Interrupt requests
   typedef struct packed {
      logic wrap;
      logic match_a;
      logic match_b;
   } ect_irq_t;

   // Pin synchroniser state and its events
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } ect_sync_t;

   typedef struct packed {
      logic level;
      logic rise;
      logic fall;
   } ect_pin_evt_t;

   // Whole state of the timer
   typedef struct packed {
      logic [`ECT_PRESC_W-1:0] prescaler;
      logic [7:0] count;
      logic [7:0] const_a;
      logic [7:0] const_b;
      logic ie_b;
      logic ie_a;
      logic ie_wrap;
      ect_clear_t clr_src;
      logic [2:0] cks;
      ect_edge_t trig_edge;
      logic gate_en;
      logic icks;
      logic flag_b;
      logic flag_a;
      logic flag_wrap;
      logic [2:0] armed;
      ect_action_t act_b;
      ect_action_t act_a;
      logic halted;
      logic sel_prev;
      logic wave;
      ect_irq_t irq;
      logic [7:0] rdata;
   } ect_state_t;

endpackage

/* File: src/ect_pin_sync.sv */
module ect_pin_sync (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_pin,
   output ect_pkg::ect_pin_evt_t o_evt
);
   import ect_pkg::*;

   ect_sync_t state;
   ect_sync_t next_state;

   // Two-stage synchroniser plus one stage for edge detection
   always_comb begin
      next_state.s1 = i_pin;
      next_state.s2 = state.s1;
      next_state.s3 = state.s2;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Events only look at the second and third stages
   assign o_evt.level = state.s2;
   assign o_evt.rise = state.s2 & ~state.s3;
   assign o_evt.fall = ~state.s2 & state.s3;
endmodule

/* File: tb/ect_pin_model.sv */
// Far-side pins: external count clock, trigger and clear
module ect_pin_model (
   input wire logic i_clk_sys,
   output logic o_ext_clk,
   output logic o_trig,
   output logic o_clr
);
   timeunit 1ns;
   timeprecision 1ns;

   // Pins idle low; the count clock stands still outside bursts
   initial begin
      o_ext_clk = 1'b0;
      o_trig = 1'b0;
      o_clr = 1'b0;
   end

   // Count clock pulses, slow enough for the pin synchroniser
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge i_clk_sys);
         o_ext_clk <= 1'b1;
         repeat (4) @(posedge i_clk_sys);
         o_ext_clk <= 1'b0;
         repeat (4) @(posedge i_clk_sys);
      end
   endtask

   // Clear pulse held two system clocks
   task automatic clear;
      @(posedge i_clk_sys);
      o_clr <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      o_clr <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
   endtask

   // Trigger level change, then settle time
   task automatic trig(input logic v);
      @(posedge i_clk_sys);
      o_trig <= v;
      repeat (4) @(posedge i_clk_sys);
   endtask
endmodule

/* File: tb/ect_timer_monitor.sv */
// Port-level checks of the timer
module ect_timer_monitor (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input ect_pkg::ect_bus_req_t i_bus,
   input wire logic i_ext_clock_pin,
   input wire logic i_trigger_input_pin,
   input wire logic i_external_clear_pin,
   input wire logic [7:0] o_rdata,
   input wire logic o_wave_output_pin,
   input ect_pkg::ect_irq_t o_irq
);
   import ect_pkg::*;

   // Read data only in the cycle after a read
   chk_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      !i_bus.rd |=> o_rdata == 8'h00) else $error("read data outside read cycle");
   chk_unmapped_zero: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      i_bus.rd && i_bus.addr > 3'h5 |=> o_rdata == 8'h00) else $error("unmapped read");
   chk_scr_ones: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      i_bus.rd && i_bus.addr == 3'h1 |=> (o_rdata & 8'hE2) == 8'hE2)
      else $error("fixed ones missing");
   chk_csr_reserved: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      i_bus.rd && i_bus.addr == 3'h2 |=> o_rdata[4]) else $error("reserved bit low");
   // Reset quiets the wave pin and every interrupt request
   chk_reset_quiet: assert property (@(posedge i_clk_sys)
      i_reset |=> !o_wave_output_pin && o_irq == '0) else $error("outputs after reset");
   // Disabling an interrupt drops its request
   chk_wrap_irq_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      i_bus.wr && i_bus.addr == 3'h0 && !i_bus.wdata[5] |-> ##[1:2] !o_irq.wrap)
      else $error("wrap request while disabled");
   chk_match_irq_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      i_bus.wr && i_bus.addr == 3'h0 && !i_bus.wdata[6] |-> ##[1:2] !o_irq.match_a)
      else $error("match request while disabled");
   // Written values read back
   chk_const_back: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      i_bus.wr && i_bus.addr == 3'h4 ##2 i_bus.rd && i_bus.addr == 3'h4
      |=> o_rdata == $past(i_bus.wdata, 3)) else $error("constant readback");
   chk_action_back: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      i_bus.wr && i_bus.addr == 3'h2 ##2 i_bus.rd && i_bus.addr == 3'h2
      |=> (o_rdata & 8'h0F) == ($past(i_bus.wdata, 3) & 8'h0F)) else $error("action readback");
endmodule

bind ect_timer ect_timer_monitor u_mon (
   .i_clk_sys(i_clk_sys),
   .i_reset(i_reset),
   .i_bus(i_bus),
   .i_ext_clock_pin(i_ext_clock_pin),
   .i_trigger_input_pin(i_trigger_input_pin),
   .i_external_clear_pin(i_external_clear_pin),
   .o_rdata(o_rdata),
   .o_wave_output_pin(o_wave_output_pin),
   .o_irq(o_irq)
);

/* File: tb/test_eight_bit_compare_timer.sv */
// Self-checking bench of the compare timer
module test_eight_bit_compare_timer;
   timeunit 1ns;
   timeprecision 1ns;
   import ect_pkg::*;

   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   ect_bus_req_t bus = '0;
   logic ext_clk;
   logic trig;
   logic clr;
   logic [7:0] rdata;
   logic wave;
   ect_irq_t irq;
   int err_count = 0;
   int checks_done = 0;
   int seed = 43623;
   logic [7:0] v;
   logic [1:0] aa;
   logic [1:0] bb;
   logic w;

   ect_timer u_dut (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_bus(bus),
      .i_ext_clock_pin(ext_clk),
      .i_trigger_input_pin(trig),
      .i_external_clear_pin(clr),
      .o_rdata(rdata),
      .o_wave_output_pin(wave),
      .o_irq(irq)
   );

   ect_pin_model u_pins (
      .i_clk_sys(i_clk_sys),
      .o_ext_clk(ext_clk),
      .o_trig(trig),
      .o_clr(clr)
   );

   // 10 MHz system clock
   initial begin
      forever #50 i_clk_sys = ~i_clk_sys;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         err_count++;
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      bus.rd <= 1'b0;
      @(posedge i_clk_sys);
      bus.wr <= 1'b0;
   endtask

   // One-cycle read; data checked in the following cycle
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge i_clk_sys);
      bus.addr <= a;
      bus.wr <= 1'b0;
      bus.rd <= 1'b1;
      @(posedge i_clk_sys);
      bus.rd <= 1'b0;
      #10;
      chk(rdata & m, e);
   endtask

   // Expected wave after matches A and B of the same cycle
   function automatic logic pick(input logic [1:0] a, input logic [1:0] b, input logic c);
      if (a == 2'h3 || b == 2'h3) return ~c;
      if (a == 2'h2 || b == 2'h2) return 1'b1;
      if (a == 2'h1 || b == 2'h1) return 1'b0;
      return c;
   endfunction

   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (60000) @(posedge i_clk_sys);
      err_count++;
      final_report();
   end

   initial begin
      repeat (6) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      // Reset values and unmapped space
      chk(wave, 1'b0);
      rd(3'h0, 8'h00, 8'hFF);
      rd(3'h1, 8'hE2, 8'hFF);
      rd(3'h2, 8'h10, 8'hFF);
      rd(3'h3, 8'h00, 8'hFF);
      rd(3'h4, 8'hFF, 8'hFF);
      rd(3'h5, 8'hFF, 8'hFF);
      wr(3'h7, 8'h55);
      rd(3'h7, 8'h00, 8'hFF);
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         wr(3'h4 + 3'(i % 2), v);
         rd(3'h4 + 3'(i % 2), v, 8'hFF);
      end
      // External rising-edge counting
      wr(3'h0, 8'h05);
      u_pins.pulse(5);
      rd(3'h3, 8'h05, 8'hFF);
      // Wrap flag, its request, and the read-then-write clear
      wr(3'h3, 8'hFE);
      wr(3'h0, 8'h25);
      u_pins.pulse(2);
      rd(3'h3, 8'h00, 8'hFF);
      chk(irq.wrap, 1'b1);
      wr(3'h2, 8'h00);
      rd(3'h2, 8'h30, 8'h30);
      wr(3'h2, 8'h00);
      rd(3'h2, 8'h10, 8'h30);
      chk(irq.wrap, 1'b0);
      // Match A toggles and clears the count
      wr(3'h4, 8'h03);
      wr(3'h0, 8'h4D);
      wr(3'h2, 8'h03);
      wr(3'h3, 8'h00);
      u_pins.pulse(4);
      rd(3'h3, 8'h00, 8'hFF);
      chk(wave, 1'b1);
      chk(irq.match_a, 1'b1);
      rd(3'h2, 8'h50, 8'h70);
      u_pins.pulse(4);
      chk(wave, 1'b0);
      // Every action code on match B
      w = 1'b0;
      wr(3'h5, 8'h01);
      wr(3'h0, 8'h15);
      wr(3'h3, 8'h00);
      for (int i = 0; i < 8; i++) begin
         bb = (i < 4) ? 2'(i) : 2'($random(seed));
         wr(3'h2, {4'h0, bb, 2'h0});
         u_pins.pulse(2);
         w = pick(2'h0, bb, w);
         chk(wave, w);
      end
      // Simultaneous matches with conflicting actions
      wr(3'h4, 8'h02);
      wr(3'h5, 8'h02);
      wr(3'h0, 8'h0D);
      wr(3'h3, 8'h00);
      for (int i = 0; i < 6; i++) begin
         aa = (i == 0) ? 2'h1 : 2'($random(seed));
         bb = (i == 0) ? 2'h3 : 2'($random(seed));
         wr(3'h2, {4'h0, bb, aa});
         u_pins.pulse(3);
         w = pick(aa, bb, w);
         chk(wave, w);
      end
      // Clear by the external pin
      wr(3'h0, 8'h1D);
      wr(3'h3, 8'h00);
      u_pins.pulse(3);
      rd(3'h3, 8'h03, 8'hFF);
      u_pins.clear();
      rd(3'h3, 8'h00, 8'hFF);
      // Gate mode with rising, then falling trigger edges
      wr(3'h1, 8'h0C);
      rd(3'h1, 8'hEE, 8'hFF);
      u_pins.pulse(2);
      rd(3'h3, 8'h00, 8'hFF);
      u_pins.trig(1'b1);
      u_pins.pulse(2);
      rd(3'h3, 8'h02, 8'hFF);
      u_pins.clear();
      u_pins.trig(1'b0);
      u_pins.pulse(1);
      rd(3'h3, 8'h00, 8'hFF);
      wr(3'h1, 8'h14);
      u_pins.trig(1'b1);
      u_pins.pulse(1);
      rd(3'h3, 8'h00, 8'hFF);
      u_pins.trig(1'b0);
      u_pins.pulse(1);
      rd(3'h3, 8'h01, 8'hFF);
      // Internal prescaled clock, about one count per four cycles
      wr(3'h0, 8'h01);
      wr(3'h3, 8'h00);
      repeat (40) @(posedge i_clk_sys);
      wr(3'h0, 8'h00);
      rd(3'h3, 8'h08, 8'hF8);
      // External falling edges, then both edges
      wr(3'h0, 8'h06);
      wr(3'h3, 8'h00);
      u_pins.pulse(2);
      rd(3'h3, 8'h02, 8'hFF);
      wr(3'h0, 8'h07);
      wr(3'h3, 8'h00);
      u_pins.pulse(2);
      rd(3'h3, 8'h04, 8'hFF);
      final_report();
   end
endmodule
